// ### core/bastl_top.sv
`default_nettype none
module bastl_top
  import bastl_pkg::*;
#(
  parameter int BLINK_HALF_CYC = BASTL_BLINK_HALF_CYC,
  parameter int TEST_HALVES = 4
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] address_switch_b_in,
  input wire logic stored_addr_valid_in,
  input wire logic [7:0] stored_last_byte_in,
  input wire logic dhcp_bound_in,
  input wire logic [31:0] dhcp_addr_in,
  input wire logic configured_in,
  input wire logic recoverable_fault_in,
  input wire logic fatal_fault_in,
  input wire logic connection_in,
  input wire logic connection_lost_in,
  input wire logic addr_conflict_in,
  input wire logic port_one_link_in,
  input wire logic port_one_fast_in,
  input wire logic port_one_activity_in,
  input wire logic port_two_link_in,
  input wire logic port_two_fast_in,
  input wire logic port_two_activity_in,
  output logic [31:0] ip_addr_out,
  output logic [31:0] subnet_mask_out,
  output logic dhcp_enable_out,
  output logic addr_valid_out,
  output logic boot_done_out,
  output logic [1:0] module_state_lamp_out,
  output logic [1:0] network_state_lamp_out,
  output logic [1:0] port_one_link_activity_lamp_out,
  output logic [1:0] port_two_link_activity_lamp_out
);
  logic [7:0] switch_b_sync;
  logic [7:0] switch_val;
  logic [7:0] sw_r;
  logic [7:0] sw_nxt;
  logic mode_dhcp_r;
  logic mode_dhcp_nxt;
  logic [7:0] fixed_byte_r;
  logic [7:0] fixed_byte_nxt;
  bastl_state_e state_r;
  bastl_state_e state_nxt;
  logic [2:0] settle_r;
  logic [31:0] blink_cnt_r;
  logic [31:0] blink_cnt_nxt;
  logic blink_r;
  logic half_tick;
  logic [7:0] test_cnt_r;
  logic [7:0] test_cnt_nxt;
  logic sample_now;
  logic in_test;
  logic in_run;
  logic [31:0] ip_nxt;
  logic addr_valid_nxt;
  logic [1:0] ms_nxt;
  logic [1:0] ns_nxt;
  logic [1:0] test_colour;
  logic [1:0] blink_green;
  logic [1:0] blink_red;

  bastl_sync #(
    .WIDTH(8)
  ) u_switch_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .async_in(address_switch_b_in),
    .stable_out(switch_b_sync)
  );

  // closed contact pulls low; bit7 is position one with weight 128
  assign switch_val = ~switch_b_sync; // R7

  // one timer for every flashing lamp
  assign half_tick = (blink_cnt_r == 32'(BLINK_HALF_CYC - 1)); // R13
  assign blink_cnt_nxt = half_tick ? 32'h0 : blink_cnt_r + 32'h1; // R13

  assign in_test = (state_r == BASTL_ST_TEST);
  assign in_run = (state_r == BASTL_ST_RUN);
  // switches are read only at the end of the settle window
  assign sample_now = (state_r == BASTL_ST_SETTLE) && (settle_r == 3'(BASTL_BOOT_SETTLE - 1)); // R2
  assign sw_nxt = sample_now ? switch_val : sw_r; // R2

  // 255 forces dhcp; zero defers to stored address if any
  assign mode_dhcp_nxt = !sample_now ? mode_dhcp_r :
                         (switch_val == BASTL_SW_DHCP) ? 1'b1 : // R4
                         (switch_val != BASTL_SW_ZERO) ? 1'b0 : // R3
                         !stored_addr_valid_in; // R5 R6
  assign fixed_byte_nxt = !sample_now ? fixed_byte_r :
                          (switch_val == BASTL_SW_ZERO) ? stored_last_byte_in : switch_val; // R3 R6

  always_comb begin
    state_nxt = state_r;
    test_cnt_nxt = test_cnt_r;
    case (state_r)
      BASTL_ST_SETTLE: begin
        if (sample_now) begin
          state_nxt = BASTL_ST_TEST;
        end
      end
      BASTL_ST_TEST: begin
        if (half_tick) begin
          test_cnt_nxt = test_cnt_r + 8'h1;
          if (test_cnt_r == 8'(TEST_HALVES - 1)) begin
            state_nxt = BASTL_ST_RUN;
          end
        end
      end
      BASTL_ST_RUN: begin
        state_nxt = BASTL_ST_RUN;
      end
      default: begin
        state_nxt = BASTL_ST_SETTLE;
      end
    endcase
  end

  // dhcp mode holds the address off until the server binds
  assign ip_nxt = mode_dhcp_r ? (dhcp_bound_in ? dhcp_addr_in : 32'h0) : {BASTL_PREFIX, fixed_byte_r}; // R1 R5
  assign addr_valid_nxt = in_run && (!mode_dhcp_r || dhcp_bound_in); // R5

  assign test_colour = blink_r ? BASTL_RED : BASTL_GREEN; // R10
  assign blink_green = blink_r ? BASTL_GREEN : BASTL_OFF; // R13
  assign blink_red = blink_r ? BASTL_RED : BASTL_OFF; // R13

  // fatal outranks recoverable outranks unconfigured
  assign ms_nxt = in_test ? test_colour : // R10
                  !in_run ? BASTL_OFF :
                  fatal_fault_in ? BASTL_RED : // R9
                  recoverable_fault_in ? blink_red : // R9
                  !configured_in ? blink_green : BASTL_GREEN; // R9

  // conflict and loss take precedence over green states
  assign ns_nxt = in_test ? test_colour : // R10
                  !in_run ? BASTL_OFF :
                  addr_conflict_in ? BASTL_RED : // R12
                  !addr_valid_nxt ? BASTL_OFF : // R11
                  connection_lost_in ? blink_red : // R12
                  connection_in ? BASTL_GREEN : blink_green; // R11

  bastl_port_lamp u_port_one (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .link_in(port_one_link_in && in_run),
    .fast_in(port_one_fast_in),
    .activity_in(port_one_activity_in),
    .blink_in(blink_r),
    .lamp_out(port_one_link_activity_lamp_out)
  );

  bastl_port_lamp u_port_two (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .link_in(port_two_link_in && in_run),
    .fast_in(port_two_fast_in),
    .activity_in(port_two_activity_in),
    .blink_in(blink_r),
    .lamp_out(port_two_link_activity_lamp_out)
  );

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r <= BASTL_ST_SETTLE;
      settle_r <= 3'h0;
      blink_cnt_r <= 32'h0;
      blink_r <= 1'b0;
      test_cnt_r <= 8'h0;
      sw_r <= 8'h0;
      mode_dhcp_r <= 1'b0;
      fixed_byte_r <= 8'h0;
    end else begin
      state_r <= state_nxt;
      settle_r <= (state_r == BASTL_ST_SETTLE) ? settle_r + 3'h1 : settle_r;
      blink_cnt_r <= blink_cnt_nxt;
      blink_r <= half_tick ? !blink_r : blink_r;
      test_cnt_r <= test_cnt_nxt;
      sw_r <= sw_nxt;
      mode_dhcp_r <= mode_dhcp_nxt;
      fixed_byte_r <= fixed_byte_nxt;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ip_addr_out <= 32'h0;
      subnet_mask_out <= 32'h0;
      dhcp_enable_out <= 1'b0;
      addr_valid_out <= 1'b0;
      boot_done_out <= 1'b0;
      module_state_lamp_out <= BASTL_OFF;
      network_state_lamp_out <= BASTL_OFF;
    end else begin
      ip_addr_out <= in_run ? ip_nxt : 32'h0;
      subnet_mask_out <= BASTL_MASK; // R1
      dhcp_enable_out <= in_run && mode_dhcp_r;
      addr_valid_out <= addr_valid_nxt;
      boot_done_out <= in_run;
      module_state_lamp_out <= ms_nxt;
      network_state_lamp_out <= ns_nxt;
    end
  end

  a_switch_frozen: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    in_run && $past(in_run) |-> $stable(sw_r)) else $error("switch copy changed after boot"); // R2
  a_fixed_prefix: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    in_run && !mode_dhcp_r |=> ip_addr_out[31:8] == BASTL_PREFIX) else $error("fixed prefix wrong"); // R1
  a_mask_fixed: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $past(rst_b_in) |-> subnet_mask_out == BASTL_MASK) else $error("mask wrong"); // R1
  a_switch_byte: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    sample_now && switch_val != 8'h00 && switch_val != 8'hff |=> !mode_dhcp_r && fixed_byte_r == $past(switch_val))
    else $error("switch byte not taken"); // R3
  a_dhcp_forced: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    sample_now && switch_val == 8'hff |=> mode_dhcp_r) else $error("255 did not force dhcp"); // R4
  a_zero_choice: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    sample_now && switch_val == 8'h00 |=> mode_dhcp_r == !$past(stored_addr_valid_in))
    else $error("zero switch choice wrong"); // R5
  a_ms_fatal: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    in_run && fatal_fault_in |=> module_state_lamp_out == BASTL_RED) else $error("fatal not red"); // R9
  a_test_alternate: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    in_test |=> module_state_lamp_out != BASTL_OFF && network_state_lamp_out == module_state_lamp_out)
    else $error("self test lamps wrong"); // R10
  a_ns_conflict: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    in_run && addr_conflict_in |=> network_state_lamp_out == BASTL_RED) else $error("conflict not red"); // R12
  a_ns_noaddr: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    in_run && !addr_conflict_in && !addr_valid_nxt |=> network_state_lamp_out == BASTL_OFF)
    else $error("no address lamp not off"); // R11
  a_blink_period: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    half_tick |=> blink_r != $past(blink_r)) else $error("blink did not toggle"); // R13

  c_reach_run: cover property (@(posedge clk_in) disable iff (!rst_b_in) $rose(in_run));
  c_dhcp_bind: cover property (@(posedge clk_in) disable iff (!rst_b_in) mode_dhcp_r && $rose(addr_valid_out));
  c_fixed_run: cover property (@(posedge clk_in) disable iff (!rst_b_in) in_run && !mode_dhcp_r);
  c_lost_conn: cover property (@(posedge clk_in) disable iff (!rst_b_in) in_run && connection_lost_in);
endmodule : bastl_top
`default_nettype wire

// ### core/bastl_pkg.sv
// Functional notes
// R1 - address is 192.168.1 plus a chosen last byte, mask 255.255.255.0
// R2 - switches are sampled once at boot; later changes ignored until reset
// R3 - switch value 1 to 254 is the last byte, dhcp off
// R4 - switch value 255 always selects dhcp, ignoring any stored address
// R5 - switch zero with nothing stored: dhcp on, wait for server address
// R6 - switch zero with a stored fixed address: use the stored address
// R7 - position one is msb weight 128, position eight lsb; closed adds weight
// R8 - port lamp: green 100M, orange 10M, steady link, flashing traffic, off no link
// R9 - module lamp: green ok, green flash unconfigured, red flash recoverable, red fault
// R10 - self test: module and network lamps alternate green and red
// R11 - network lamp: off no address, green connected, green flash address only
// R12 - network lamp: red flash connection lost, red steady address conflict
// R13 - one common blink timer drives all flashing; lamp outputs active high
`default_nettype none
package bastl_pkg;
  localparam logic [23:0] BASTL_PREFIX = 24'hc0a801;
  localparam logic [31:0] BASTL_MASK = 32'hffffff00;
  localparam logic [7:0] BASTL_SW_ZERO = 8'h00;
  localparam logic [7:0] BASTL_SW_DHCP = 8'hff;
  localparam int BASTL_CLK_MHZ = 100;
  localparam int BASTL_BLINK_HALF_MS = 250;
  localparam int BASTL_BLINK_HALF_CYC = BASTL_BLINK_HALF_MS * 1000 * BASTL_CLK_MHZ;
  localparam int BASTL_SYNC_STAGES = 3;
  // the switch sync output is only trustworthy from the fourth edge after release
  localparam int BASTL_BOOT_SETTLE = 5;
  // lamp colour encoding: bit0 green, bit1 red; both lit shows orange
  localparam logic [1:0] BASTL_OFF = 2'h0;
  localparam logic [1:0] BASTL_GREEN = 2'h1;
  localparam logic [1:0] BASTL_RED = 2'h2;
  localparam logic [1:0] BASTL_ORANGE = 2'h3;
  typedef enum logic [1:0] {
    BASTL_ST_SETTLE = 2'h0,
    BASTL_ST_TEST = 2'h1,
    BASTL_ST_RUN = 2'h2
  } bastl_state_e;
endpackage : bastl_pkg
`default_nettype wire

// ### core/bastl_sync.sv
`default_nettype none
module bastl_sync
  import bastl_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] stable_out
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] stable_nxt;
  // a change is taken only once stages two and three agree
  assign stable_nxt = (s2_r == s3_r) ? s3_r : stable_out;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      stable_out <= '0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      stable_out <= stable_nxt;
    end
  end
endmodule : bastl_sync
`default_nettype wire

// ### core/bastl_port_lamp.sv
`default_nettype none
module bastl_port_lamp
  import bastl_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic link_in,
  input wire logic fast_in,
  input wire logic activity_in,
  input wire logic blink_in,
  output logic [1:0] lamp_out
);
  logic [1:0] colour;
  logic [1:0] lamp_nxt;
  assign colour = fast_in ? BASTL_GREEN : BASTL_ORANGE; // R8
  assign lamp_nxt = !link_in ? BASTL_OFF : (activity_in && !blink_in) ? BASTL_OFF : colour; // R8 R13
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lamp_out <= BASTL_OFF;
    end else begin
      lamp_out <= lamp_nxt;
    end
  end
endmodule : bastl_port_lamp
`default_nettype wire

// ### verification/bastl_dhcp_server.sv
`default_nettype none
module bastl_dhcp_server #(
  parameter logic [31:0] LEASE_ADDR = 32'h0a000005,
  parameter int DELAY = 40
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic dhcp_enable_in,
  output logic bound_out,
  output logic [31:0] addr_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int wait_r;
  // before the lease the address lines carry junk, so the block must not trust them unbound
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wait_r <= 0;
      bound_out <= 1'b0;
      addr_out <= ~LEASE_ADDR;
    end else if (dhcp_enable_in && wait_r < DELAY) begin
      wait_r <= wait_r + 1;
      addr_out <= ~addr_out;
    end else if (dhcp_enable_in) begin
      bound_out <= 1'b1;
      addr_out <= LEASE_ADDR;
    end
  end
endmodule : bastl_dhcp_server
`default_nettype wire

// ### verification/boot_address_select_status_leds_tb.sv
`default_nettype none
module boot_address_select_status_leds_tb
  import bastl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = 4;
  localparam logic [31:0] LEASE = 32'h0a000005;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [7:0] sw_b = 8'hff;
  logic [7:0] stored_b = 8'h00;
  logic [7:0] rnd = 8'h13;
  logic stored_v = 1'b0, configured = 1'b0, rec = 1'b0, fatal = 1'b0, conn = 1'b0, lost = 1'b0, confl = 1'b0;
  // phy bits: port one link, fast, activity, then port two in the same order
  logic [5:0] phy = 6'h00;
  logic bound, dhcp_en, valid, done;
  logic [31:0] lease, ip, mask;
  logic [1:0] lamp [4];
  int fails = 0;
  int samples_checked = 0;
  always #5 clk_in = ~clk_in;
  bastl_dhcp_server #(.LEASE_ADDR(LEASE), .DELAY(40)) server (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .dhcp_enable_in(dhcp_en), .bound_out(bound), .addr_out(lease));
  bastl_top #(.BLINK_HALF_CYC(HALF), .TEST_HALVES(4)) dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .address_switch_b_in(sw_b), .stored_addr_valid_in(stored_v), .stored_last_byte_in(stored_b),
    .dhcp_bound_in(bound), .dhcp_addr_in(lease), .configured_in(configured), .recoverable_fault_in(rec),
    .fatal_fault_in(fatal), .connection_in(conn), .connection_lost_in(lost), .addr_conflict_in(confl),
    .port_one_link_in(phy[0]), .port_one_fast_in(phy[1]), .port_one_activity_in(phy[2]),
    .port_two_link_in(phy[3]), .port_two_fast_in(phy[4]), .port_two_activity_in(phy[5]),
    .ip_addr_out(ip), .subnet_mask_out(mask), .dhcp_enable_out(dhcp_en), .addr_valid_out(valid),
    .boot_done_out(done), .module_state_lamp_out(lamp[0]), .network_state_lamp_out(lamp[1]),
    .port_one_link_activity_lamp_out(lamp[2]), .port_two_link_activity_lamp_out(lamp[3]));
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr
  function automatic logic [1:0] port_colour(input logic link, input logic fast);
    return link ? (fast ? BASTL_GREEN : BASTL_ORANGE) : BASTL_OFF;
  endfunction : port_colour
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick
  // switch is closed-low, so the wanted value goes out inverted
  task automatic boot(input logic [7:0] sw, input logic sv, input logic [7:0] sb);
    int gm, rm, gn, rn, n;
    gm = 0; rm = 0; gn = 0; rn = 0;
    @(posedge clk_in);
    rst_b_in <= 1'b0;
    sw_b <= ~sw;
    stored_v <= sv;
    stored_b <= sb;
    repeat (5) @(posedge clk_in);
    rst_b_in <= 1'b1;
    for (n = 0; n < 200 && done !== 1'b1; n++) begin
      tick(1);
      gm += (lamp[0] === BASTL_GREEN);
      rm += (lamp[0] === BASTL_RED);
      gn += (lamp[1] === BASTL_GREEN);
      rn += (lamp[1] === BASTL_RED);
    end
    if (done !== 1'b1) begin
      fails++;
      summarize();
    end
    chk("self test lamps", {gm > 0, rm > 0, gn > 0, rn > 0}, 4'hf);
    chk("subnet mask", mask, BASTL_MASK);
    @(posedge clk_in);
    sw_b <= sw ^ 8'h5a;
    #1;
  endtask : boot
  // flashing shares one timer, so any window of two halves holds exactly one half lit
  task automatic lamp_chk(input string name, input int idx, input logic [1:0] colour, input int on_exp);
    int on, off;
    on = 0; off = 0;
    tick(3);
    repeat (2 * HALF) begin
      if (lamp[idx] === colour) on++;
      else if (lamp[idx] === BASTL_OFF) off++;
      tick(1);
    end
    chk(name, {on[7:0], 8'(on + off)}, {on_exp[7:0], 8'(2 * HALF)});
  endtask : lamp_chk
  initial begin
    int i, k, n;
    logic [7:0] v;
    for (i = 0; i < 5; i++) begin
      v = (i == 0) ? 8'h01 : (i == 1) ? 8'hfe : rnd;
      rnd = lfsr(rnd);
      if (v == 8'h00 || v == 8'hff) v = 8'h2a;
      boot(v, i[0], 8'h33);
      tick(12);
      chk("fixed address", ip, {BASTL_PREFIX, v});
      chk("dhcp off", dhcp_en, 1'b0);
    end
    $display("fixed address test done");
    for (k = 0; k < 4; k++) begin
      @(posedge clk_in);
      fatal <= (k == 0);
      rec <= (k == 1);
      configured <= (k != 2);
      confl <= (k == 0);
      lost <= (k == 1);
      conn <= (k == 2);
      lamp_chk("module lamp", 0, k < 2 ? BASTL_RED : BASTL_GREEN, (k == 0 || k == 3) ? 8 : 4);
      lamp_chk("network lamp", 1, k < 2 ? BASTL_RED : BASTL_GREEN, (k == 1 || k == 3) ? 4 : 8);
    end
    for (k = 0; k < 8; k++) begin
      @(posedge clk_in);
      phy <= {k[2], ~k[1], k[0], k[2:0]};
      lamp_chk("port one lamp", 2, port_colour(k[0], k[1]), (k[0] && k[2]) ? 4 : 8);
      lamp_chk("port two lamp", 3, port_colour(k[0], !k[1]), (k[0] && k[2]) ? 4 : 8);
    end
    $display("lamp test done");
    for (k = 0; k < 2; k++) begin
      boot(k == 0 ? BASTL_SW_DHCP : BASTL_SW_ZERO, k == 0, 8'h33);
      chk("dhcp enable", dhcp_en, 1'b1);
      chk("early valid", valid, 1'b0);
      chk("early address", ip, 32'h0);
      lamp_chk("network lamp", 1, BASTL_OFF, 8);
      for (n = 0; n < 100 && valid !== 1'b1; n++) tick(1);
      if (valid !== 1'b1) begin
        fails++;
        summarize();
      end
      tick(2);
      chk("dhcp address", ip, LEASE);
    end
    $display("dhcp test done");
    boot(BASTL_SW_ZERO, 1'b1, 8'h21);
    tick(12);
    chk("stored address", ip, {BASTL_PREFIX, 8'h21});
    chk("stored dhcp off", dhcp_en, 1'b0);
    $display("stored address test done");
    summarize();
  end
endmodule : boot_address_select_status_leds_tb
`default_nettype wire
